//--- rtl/eep_slave.sv
// Two-wire serial memory slave: bus decoder, page buffer and self-timed programming.
// Assumes an external pull-up on the data wire and strap pins tied low when unused.
//
// What this block does
// RULE1: Holds a 4096-byte array, one byte per 12-bit address.
// RULE2: Groups the array into 32-byte pages; one program cycle updates one page.
// RULE3: Partial page writes program only the bytes actually received.
// RULE4: Programming is self-timed and ends within the 5 ms maximum.
// RULE5: While reset is high, bus traffic is ignored and nothing is acknowledged.
// RULE6: Reset release clears the machine into standby awaiting a start.
// RULE7: Reset during programming forces standby and cancels any programming.
// RULE8: After stop, standby follows at once or after programming completes.
// RULE9: Write guard high stops any new programming; a page cycle already running still completes.
// RULE10: Write guard low allows normal byte and page programming.
// RULE11: Unconnected straps read as zero.
// RULE12: Respond only when select strap bits match the strap inputs.
// RULE13: Data wire is only pulled low or released, never driven high.
// RULE14: Master sends select byte, then address, then data bytes.
// RULE15: Select byte is type code, three strap bits, then direction bit.
// RULE16: Direction bit one means read, zero means write.
// RULE17: Page load increments only the low five address bits, wrapping in page.
// RULE18: Select byte is not acknowledged while programming runs.
// RULE19: Address arrives as two bytes, high first, unused top bits zero.
// RULE20: Guarded writes are acknowledged but start no programming at stop.
module eep_slave
  import eep_pkg::*;
#(
  parameter int         PROG_CYCLES = PROG_CYCLES_DEF,
  parameter logic [3:0] DEV_TYPE    = DEV_TYPE_DEF
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  input  wire logic wp_i,
  input  wire logic select_strap_bit0,
  input  wire logic select_strap_bit1,
  input  wire logic select_strap_bit2,
  output logic      prog_busy
);

  if (PROG_CYCLES <= PAGE_BYTES || PROG_CYCLES >= (1 << PROG_CNT_W)) begin : g_chk
    $error("PROG_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic       scl_q;
  logic       sda_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
      scl_q    <= 1'b0;
      sda_q    <= 1'b0;
    end else begin
      pin_meta <= {select_strap_bit2, select_strap_bit1, select_strap_bit0, wp_i, sda_i, scl_i};
      pin_sync <= pin_meta;
      scl_q    <= pin_sync[0];
      sda_q    <= pin_sync[1];
    end
  end

  logic       scl_s;
  logic       sda_s;
  logic       wp_s;
  logic [2:0] strap_s;
  assign scl_s   = pin_sync[0];
  assign sda_s   = pin_sync[1];
  assign wp_s    = pin_sync[2];
  assign strap_s = pin_sync[5:3]; // see RULE11

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0]        mem [MEM_BYTES];
  logic [7:0]        page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Bus state machine
  eep_state_t        state;
  eep_phase_t        phase;
  logic [2:0]        bit_cnt;
  logic              byte_done;
  logic [7:0]        rx_shift;
  logic [7:0]        tx_shift;
  logic              tx_mode;
  logic              master_ack;
  logic [ADDR_W-1:0] addr;
  logic [PAGE_W-1:0] page_hi;
  logic              wr_pending;
  logic              page_clr;
  logic              fifo_in_ready;

  logic sel_match;
  logic take_byte;
  logic ack_now;
  logic push;
  assign sel_match = rx_shift[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEV_TYPE &&
                     rx_shift[SEL_STRAP_MSB:SEL_STRAP_LSB] == strap_s; // see RULE12
  assign take_byte = state == ST_RX && scl_fall && byte_done && !start_det && !stop_det;

  always_comb begin
    case (phase)
      PH_SEL:  ack_now = sel_match && !prog_busy; // see RULE18
      PH_AHI:  ack_now = 1'b1;
      PH_ALO:  ack_now = 1'b1;
      PH_DATA: ack_now = fifo_in_ready; // see RULE20
      default: ack_now = 1'b0;
    endcase
  end
  assign push     = take_byte && ack_now && phase == PH_DATA;
  assign page_clr = take_byte && phase == PH_ALO;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin // see RULE5
      state      <= ST_IDLE; // see RULE6
      phase      <= PH_SEL;
      bit_cnt    <= BIT_FIRST;
      byte_done  <= 1'b0;
      rx_shift   <= 8'h00;
      tx_shift   <= 8'h00;
      tx_mode    <= 1'b0;
      master_ack <= 1'b0;
      addr       <= '0;
      page_hi    <= '0;
      sda_oe     <= 1'b0;
    end else if (start_det) begin
      state     <= ST_RX;
      phase     <= PH_SEL;
      bit_cnt   <= BIT_FIRST;
      byte_done <= 1'b0;
      tx_mode   <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (stop_det) begin
      state  <= ST_IDLE; // see RULE8
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_RX: begin
          if (scl_rise) begin
            rx_shift  <= {rx_shift[6:0], sda_s};
            bit_cnt   <= bit_cnt + 3'h1;
            byte_done <= bit_cnt == BIT_LAST;
          end else if (take_byte) begin
            byte_done <= 1'b0;
            if (ack_now) begin
              sda_oe <= 1'b1;
              state  <= ST_ACK;
              case (phase)
                PH_SEL: begin // see RULE15
                  tx_mode <= rx_shift[SEL_RW_BIT] == RW_READ; // see RULE16
                  phase   <= rx_shift[SEL_RW_BIT] == RW_READ ? PH_DATA : PH_AHI;
                end
                PH_AHI: begin // see RULE19
                  addr[ADDR_W-1:8] <= rx_shift[AHI_MSB:0];
                  phase            <= PH_ALO;
                end
                PH_ALO: begin
                  addr[7:0] <= rx_shift;
                  // Page comes from the byte just received, not the old pointer
                  page_hi   <= {addr[ADDR_W-1:8], rx_shift[7:SLOT_W]};
                  phase     <= PH_DATA;
                end
                default: begin // see RULE17
                  addr[SLOT_W-1:0] <= eep_inc_slot(addr[SLOT_W-1:0]);
                end
              endcase
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt <= BIT_FIRST;
            if (tx_mode) begin
              tx_shift <= mem[addr];
              sda_oe   <= ~mem[addr][7];
              addr     <= addr + 12'h001;
              state    <= ST_TX;
            end else begin
              sda_oe <= 1'b0;
              state  <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt == BIT_LAST) begin
              sda_oe <= 1'b0;
              state  <= ST_TXACK;
            end else begin
              sda_oe   <= ~tx_shift[6]; // see RULE13
              tx_shift <= {tx_shift[6:0], 1'b0};
              bit_cnt  <= bit_cnt + 3'h1;
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            master_ack <= sda_s == ACK_LEVEL;
          end else if (scl_fall) begin
            if (master_ack) begin
              tx_shift <= mem[addr];
              sda_oe   <= ~mem[addr][7];
              addr     <= addr + 12'h001;
              bit_cnt  <= BIT_FIRST;
              state    <= ST_TX;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_o <= 1'b0; // see RULE13
    end else begin
      sda_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer between byte receiver and page buffer
  eep_word_t fifo_mem [2];
  logic      fifo_wp;
  logic      fifo_rp;
  logic [1:0] fifo_cnt;
  logic      fifo_out_valid;
  logic      fifo_out_ready;
  logic      pop;
  assign fifo_in_ready  = fifo_cnt != 2'h2;
  assign fifo_out_valid = fifo_cnt != 2'h0;
  assign fifo_out_ready = !prog_busy;
  assign pop            = fifo_out_valid && fifo_out_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifo_wp  <= 1'b0;
      fifo_rp  <= 1'b0;
      fifo_cnt <= 2'h0;
    end else begin
      if (push) begin
        fifo_mem[fifo_wp] <= '{slot: addr[SLOT_W-1:0], data: rx_shift};
        fifo_wp           <= ~fifo_wp;
      end
      if (pop) begin
        fifo_rp <= ~fifo_rp;
      end
      fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer and programming
  logic                  prog_req;
  logic                  prog_start;
  logic                  prog_done;
  logic                  mem_we;
  logic [PROG_CNT_W-1:0] prog_cnt;
  assign prog_start = prog_req && !wp_s && !fifo_out_valid && !prog_busy; // see RULE9
  assign prog_done  = prog_busy && prog_cnt == PROG_CNT_W'(PROG_CYCLES - 1); // see RULE4
  assign mem_we     = prog_busy && prog_cnt < PROG_CNT_W'(PAGE_BYTES) &&
                      page_valid[prog_cnt[SLOT_W-1:0]]; // see RULE3

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      page_valid <= '0;
    end else begin
      if (page_clr || prog_done) begin
        page_valid <= '0;
      end
      if (pop) begin
        page_buf[fifo_mem[fifo_rp].slot]   <= fifo_mem[fifo_rp].data;
        page_valid[fifo_mem[fifo_rp].slot] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin // see RULE7
      wr_pending <= 1'b0;
      prog_req   <= 1'b0;
    end else begin
      if (start_det || stop_det) begin
        wr_pending <= 1'b0;
      end else if (push) begin
        wr_pending <= 1'b1;
      end
      if (stop_det && wr_pending && !wp_s) begin // see RULE10
        prog_req <= 1'b1;
      end else if (prog_start || wp_s) begin // see RULE20
        prog_req <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_busy <= 1'b0;
      prog_cnt  <= '0;
    end else if (prog_start) begin
      prog_busy <= 1'b1;
      prog_cnt  <= '0;
    end else if (prog_done) begin
      prog_busy <= 1'b0;
    end else if (prog_busy) begin
      prog_cnt <= prog_cnt + PROG_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin // see RULE1
      mem[{page_hi, prog_cnt[SLOT_W-1:0]}] <= page_buf[prog_cnt[SLOT_W-1:0]]; // see RULE2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_prog_begin;
    !prog_busy ##1 prog_busy;
  endsequence

  sequence s_prog_hold;
    prog_busy [*8];
  endsequence

  a_sda_low_only: assert property (@(posedge clk) disable iff (rst) sda_o == 1'b0) // see RULE13
    else $error("data wire driven high");
  a_reset_idle: assert property (@(posedge clk) $fell(rst) |-> !sda_oe && state == ST_IDLE && !prog_busy) // see RULE6
    else $error("not in standby after reset");
  a_prog_hold: assert property (@(posedge clk) disable iff (rst) s_prog_begin |-> s_prog_hold) // see RULE4
    else $error("programming ended too early");
  a_prog_bound: assert property (@(posedge clk) disable iff (rst)
      prog_busy |-> prog_cnt < PROG_CNT_W'(PROG_CYCLES)) // see RULE4
    else $error("programming overran its limit");
  a_busy_nack: assert property (@(posedge clk) disable iff (rst)
      take_byte && phase == PH_SEL && prog_busy |=> state == ST_IDLE && !sda_oe) // see RULE18
    else $error("select acknowledged while busy");
  a_guard_block: assert property (@(posedge clk) disable iff (rst) prog_start |-> !wp_s && !$past(wp_s)) // see RULE9
    else $error("programming started under guard");
  a_strap_match: assert property (@(posedge clk) disable iff (rst)
      take_byte && phase == PH_SEL && sda_oe == 1'b0 ##1 state == ST_ACK |-> $past(sel_match)) // see RULE12
    else $error("acknowledged foreign select");
  a_page_wrap: assert property (@(posedge clk) disable iff (rst)
      push |=> addr[SLOT_W-1:0] == eep_inc_slot($past(addr[SLOT_W-1:0])) &&
               addr[ADDR_W-1:SLOT_W] == $past(addr[ADDR_W-1:SLOT_W])) // see RULE17
    else $error("page address did not wrap");
  a_partial_only: assert property (@(posedge clk) disable iff (rst)
      mem_we |-> prog_busy && page_valid[prog_cnt[SLOT_W-1:0]]) // see RULE3
    else $error("unreceived byte programmed");
  a_stop_idle: assert property (@(posedge clk) disable iff (rst) stop_det |=> state == ST_IDLE ##1 !sda_oe) // see RULE8
    else $error("no standby after stop");

endmodule

//--- rtl/eep_pkg.sv
// Constants, types and helpers shared by the two-wire memory slave.
// Assumes a single 250 MHz system clock samples the bus pins.
package eep_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Array organisation
  localparam int MEM_BYTES  = 4096;
  localparam int ADDR_W     = 12;
  localparam int PAGE_BYTES = 32;
  localparam int SLOT_W     = 5;
  localparam int PAGE_W     = ADDR_W - SLOT_W;

  ////////////////////////////////////////////////////////////////////////////
  // Select byte layout
  localparam int SEL_RW_BIT    = 0;
  localparam int SEL_STRAP_LSB = 1;
  localparam int SEL_STRAP_MSB = 3;
  localparam int SEL_TYPE_LSB  = 4;
  localparam int SEL_TYPE_MSB  = 7;
  localparam int AHI_MSB       = ADDR_W - 9;
  localparam logic       RW_READ      = 1'b1;
  localparam logic       ACK_LEVEL    = 1'b0;
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic [2:0] BIT_FIRST    = 3'h0;
  // Device-type code: value is arbitrary
  localparam logic [3:0] DEV_TYPE_DEF = 4'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS   = 4;
  localparam int T_WRITE_MAX_MS  = 5;
  localparam int PROG_CYCLES_DEF = (T_WRITE_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int PROG_CNT_W      = 21;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} eep_state_t;
  typedef enum logic [1:0] {PH_SEL, PH_AHI, PH_ALO, PH_DATA} eep_phase_t;

  typedef struct packed {
    logic [SLOT_W-1:0] slot;
    logic [7:0]        data;
  } eep_word_t;

  // Next slot inside the page, wrapping at the page edge
  function automatic logic [SLOT_W-1:0] eep_inc_slot(input logic [SLOT_W-1:0] s);
    return s + 5'h01;
  endfunction

endpackage

//--- sim/eep_master.sv
// Bus master model: drives the serial clock and pulls the data wire low.
// Assumes the bench resolves the data wire with a pull-up.
module eep_master (
  input  wire logic clk,
  output logic      scl,
  output logic      pull,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl  = 1'b1;
    pull = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic start();
    pull = 1'b0;
    w(10);
    scl = 1'b1;
    w(10);
    pull = 1'b1;
    w(10);
    scl = 1'b0;
    w(10);
  endtask

  // Returns with data released while the clock is high
  task automatic stop();
    pull = 1'b1;
    w(10);
    scl = 1'b1;
    w(10);
    pull = 1'b0;
  endtask

  // One clock pulse: offer a bit, sample the wire late in the high phase
  task automatic bit1(input logic b, output logic s);
    pull = ~b;
    w(10);
    scl = 1'b1;
    w(9);
    s = sda;
    w(1);
    scl = 1'b0;
    w(2);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit1(d[i], s);
    end
    bit1(1'b1, s);
    ack = (s === 1'b0);
  endtask

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit1(1'b1, s);
      d[i] = s;
    end
    bit1(last, s);
  endtask

  task automatic sel(input logic [3:0] t, input logic [2:0] s, input logic rw, output logic ack);
    wbyte({t, s, rw}, ack);
  endtask

  task automatic addr(input logic [11:0] a, output logic ack);
    logic a1;
    wbyte({4'h0, a[11:8]}, a1);
    wbyte(a[7:0], ack);
    ack = ack & a1;
  endtask
endmodule

//--- sim/eep_slave_test.sv
// Self-checking bench for the two-wire memory slave.
// Assumes the master model in eep_master.sv and a pull-up on the data wire.
module eep_slave_test;
  import eep_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int         PROG  = 600;
  localparam logic [3:0] DEV   = 4'h6; // Arbitrary type code
  localparam logic [2:0] STRAP = 3'h5;

  logic       clk;
  logic       rst;
  logic       wp;
  logic       scl;
  logic       pull;
  logic       sda;
  logic       sda_o;
  logic       sda_oe;
  logic       prog_busy;
  logic       ack;
  logic [7:0] d;
  logic [2:0] strap;
  int         n_fail;
  int         comparisons;

  // Open-drain wire with pull-up
  assign sda = ~pull & ~(sda_oe & ~sda_o);

  eep_master i_eep_master (.clk(clk), .scl(scl), .pull(pull), .sda(sda));

  eep_slave #(.PROG_CYCLES(PROG), .DEV_TYPE(DEV)) i_eep_slave (
    .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp),
    .select_strap_bit0(strap[0]), .select_strap_bit1(strap[1]), .select_strap_bit2(strap[2]),
    .prog_busy(prog_busy));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(negedge clk) begin
    if (sda_oe === 1'b1) begin
      chk("pull level", 0, sda_o);
    end
  end

  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic head(input logic [11:0] a);
    i_eep_master.start();
    i_eep_master.sel(DEV, STRAP, 1'b0, ack);
    chk("write select ack", 1, ack);
    i_eep_master.addr(a, ack);
    chk("address ack", 1, ack);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] q[$]);
    head(a);
    foreach (q[i]) begin
      i_eep_master.wbyte(q[i], ack);
      chk("data ack", 1, ack);
    end
    i_eep_master.stop();
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    head(a);
    i_eep_master.start();
    i_eep_master.sel(DEV, STRAP, 1'b1, ack);
    chk("read select ack", 1, ack);
    i_eep_master.rbyte(1'b1, d);
    chk("read data", exp, d);
    i_eep_master.stop();
    i_eep_master.w(10);
  endtask

  task automatic poll(input logic [3:0] t, input logic [2:0] s, input logic exp);
    i_eep_master.start();
    i_eep_master.sel(t, s, 1'b0, ack);
    chk("select ack", exp, ack);
    i_eep_master.stop();
    i_eep_master.w(10);
  endtask

  task automatic up(input logic exp);
    int n;
    n = 0;
    while (prog_busy !== 1'b1 && n < 16) begin
      @(negedge clk);
      n++;
    end
    chk("busy start", exp, prog_busy);
  endtask

  task automatic down(input int len);
    int n;
    n = 0;
    while (prog_busy === 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n == 2000) begin
      n_fail++;
      results();
    end
    if (len > 0) begin
      chk("busy length", len, n);
    end
    i_eep_master.w(10);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rst = 1'b1;
    poll(DEV, STRAP, 1'b0);
    chk("busy in reset", 0, prog_busy);
    rst = 1'b0;
    i_eep_master.w(10);
    poll(DEV, STRAP, 1'b1);
  endtask

  task automatic t_page();
    wr(12'hFE0, '{8'h11, 8'h22, 8'h33});
    up(1'b1);
    down(PROG);
    wr(12'hFFE, '{8'hA1, 8'hA2, 8'hA3});
    up(1'b1);
    down(PROG);
    rd(12'hFFE, 8'hA1);
    rd(12'hFFF, 8'hA2);
    rd(12'hFE0, 8'hA3);
    rd(12'hFE1, 8'h22);
  endtask

  task automatic t_poll();
    wr(12'h100, '{8'h5A});
    up(1'b1);
    poll(DEV, STRAP, 1'b0);
    down(0);
    poll(DEV, STRAP, 1'b1);
    rd(12'h100, 8'h5A);
  endtask

  task automatic t_strap();
    for (int i = 0; i < 3; i++) begin
      poll(DEV, STRAP ^ (3'h1 << i), 1'b0);
    end
    poll(DEV ^ 4'h1, STRAP, 1'b0);
    strap = 3'h0;
    poll(DEV, 3'h0, 1'b1);
    poll(DEV, STRAP, 1'b0);
    strap = STRAP;
  endtask

  task automatic t_guard();
    wp = 1'b1;
    wr(12'h100, '{8'hC3});
    up(1'b0);
    wp = 1'b0;
    rd(12'h100, 8'h5A);
  endtask

  task automatic t_abort();
    wr(12'h200, '{8'h77});
    up(1'b1);
    rst = 1'b1;
    i_eep_master.w(4);
    chk("busy in reset", 0, prog_busy);
    chk("enable in reset", 0, sda_oe);
    rst = 1'b0;
    up(1'b0);
    poll(DEV, STRAP, 1'b1);
  endtask

  initial begin
    rst = 1'b1;
    wp = 1'b0;
    strap = STRAP;
    n_fail = 0;
    comparisons = 0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    i_eep_master.w(10);
    t_reset();
    t_page();
    t_poll();
    t_strap();
    t_guard();
    t_abort();
    results();
  end
endmodule
